// ---- hw/smt_pkg.sv ----
// Summary of operation
// - run flag lags by one extra cycle in synchronous modes only
// - polarity select one inverts that input
// - single acquisition stops counter, clears run
// - repeat acquisition keeps counting, overwrites result
// - timer mode counts while run set
// - timer mode ignores inputs, uses timer clock
// - period match zeroes counter, raises flag
// - codes 0000-0111 are synchronous modes
// - codes 1000-1010 counter modes, rest reserved
// - 24-bit period in three bytes, ones
package smt_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_PERIOD_LOW = 8'h08;
  localparam logic [7:0] ADDR_PERIOD_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_PERIOD_UPPER = 8'h10;
  localparam logic [7:0] ADDR_COUNT      = 8'h14;
  localparam logic [7:0] ADDR_RESULT     = 8'h18;
  // ----------------------------------------------------------------
  // control and status field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_RUN_BIT    = 4;
  localparam int CTRL_REPEAT_BIT = 5;
  localparam int CTRL_WINDOW_POLARITY_SELECT_BIT   = 6;
  localparam int CTRL_SIGNAL_POLARITY_SELECT_BIT   = 7;
  localparam int CTRL_CLOCK_POLARITY_SELECT_BIT   = 8;
  localparam int STAT_RUN_BIT    = 0;
  localparam int STAT_MATCH_BIT  = 1;
  localparam int STAT_ACQ_BIT    = 2;
  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [23:0] PERIOD_RESET = 24'hFFFFFF;
  localparam logic [3:0]  MODE_RESET   = 4'h0;
  localparam int          SYNC_STAGES  = 2;
  // ----------------------------------------------------------------
  // mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_TIMER       = 4'h0;
  localparam logic [3:0] MODE_GATED_TIMER = 4'h1;
  localparam logic [3:0] MODE_PERIOD_DUTY = 4'h2;
  localparam logic [3:0] MODE_HIGH_LOW    = 4'h3;
  localparam logic [3:0] MODE_WINDOWED    = 4'h4;
  localparam logic [3:0] MODE_GATED_WIN   = 4'h5;
  localparam logic [3:0] MODE_FLIGHT      = 4'h6;
  localparam logic [3:0] MODE_CAPTURE     = 4'h7;
  localparam logic [3:0] MODE_COUNTER     = 4'h8;
  localparam logic [3:0] MODE_GATED_CNT   = 4'h9;
  localparam logic [3:0] MODE_WIN_CNT     = 4'hA;
endpackage : smt_pkg

// ---- hw/smt_sync_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface smt_sync_if;
  logic sig_level;   // conditioned signal level
  logic win_level;   // conditioned window level
  logic clk_tick;    // timer clock source rising edge
  logic sig_rise;    // signal rising edge
  logic win_rise;    // window rising edge
  logic win_fall;    // window falling edge
  modport source (output sig_level, win_level, clk_tick, sig_rise,
                  win_rise, win_fall);
  modport sink   (input sig_level, win_level, clk_tick, sig_rise,
                  win_rise, win_fall);
endinterface : smt_sync_if
`default_nettype wire

// ---- hw/smt_input_cond.sv ----
`timescale 1ns/10ps
`default_nettype none
module smt_input_cond
  import smt_pkg::*;
(
  input  wire logic   clk_in,          // system clock
  input  wire logic   reset_in,        // synchronous reset
  input  wire logic   sig_in,          // measured signal pin
  input  wire logic   win_in,          // window pin
  input  wire logic   tclk_in,         // timer clock source pin
  input  wire logic   window_polarity_select_in,         // window polarity select
  input  wire logic   signal_polarity_select_in,         // signal polarity select
  input  wire logic   clock_polarity_select_in,         // clock polarity select
  smt_sync_if.source  cond             // conditioned events
);
  // ----------------------------------------------------------------
  // two-stage synchronisers; first stage feeds only the second
  // ----------------------------------------------------------------
  logic [2:0] stage1;
  logic [2:0] stage2;
  logic [2:0] prev;
  logic [2:0] pol;

  assign pol = {clock_polarity_select_in, window_polarity_select_in, signal_polarity_select_in};

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      stage1 <= 3'h0;
      stage2 <= 3'h0;
      prev   <= 3'h0;
    end
    else
    begin
      stage1 <= {tclk_in, win_in, sig_in};
      stage2 <= stage1;
      prev   <= stage2 ^ pol;
    end
  end

  // ----------------------------------------------------------------
  // polarity and edges
  // ----------------------------------------------------------------
  wire [2:0] level = stage2 ^ pol;
  assign cond.sig_level = level[0];
  assign cond.win_level = level[1];
  assign cond.clk_tick  = level[2] & ~prev[2];
  assign cond.sig_rise  = level[0] & ~prev[0];
  assign cond.win_rise  = level[1] & ~prev[1];
  assign cond.win_fall  = ~level[1] & prev[1];
endmodule : smt_input_cond
`default_nettype wire

// ---- hw/smt_core.sv ----
`timescale 1ns/10ps
`default_nettype none
module smt_core
  import smt_pkg::*;
(
  input  wire logic        clk_in,      // 20 MHz clock
  input  wire logic        reset_in,    // synchronous reset, high
  input  wire logic        psel_in,     // apb select
  input  wire logic        penable_in,  // apb enable
  input  wire logic        pwrite_in,   // apb direction
  input  wire logic [7:0]  paddr_in,    // apb byte address
  input  wire logic [31:0] pwdata_in,   // apb write data
  input  wire logic [3:0]  pstrb_in,    // apb byte strobes
  output logic      [31:0] prdata_out,  // apb read data
  output logic             pready_out,  // apb ready
  output logic             pslverr_out, // apb error
  input  wire logic        signal_in,   // measured signal input pin
  input  wire logic        window_in,   // window input pin
  input  wire logic        tclk_in,     // timer clock source pin
  output logic             run_status_out, // run status flag
  output logic             match_out    // period match pulse
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [3:0]  mode;
  logic        run_request_bit;
  logic        repeat_acq;
  logic        window_polarity_select;
  logic        signal_polarity_select;
  logic        clock_polarity_select;
  logic [23:0] period_value;
  logic [23:0] count_value;
  logic [23:0] result;
  logic        match_flag;
  logic        acq_flag;
  logic        run_status_flag;
  logic        run_lag;
  logic        armed;

  smt_sync_if cond ();

  smt_input_cond u_cond (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .sig_in   (signal_in),
    .win_in   (window_in),
    .tclk_in  (tclk_in),
    .window_polarity_select_in  (window_polarity_select),
    .signal_polarity_select_in  (signal_polarity_select),
    .clock_polarity_select_in  (clock_polarity_select),
    .cond     (cond)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire wr_en  = psel_in & penable_in & pwrite_in;
  wire rd_en  = psel_in & penable_in & ~pwrite_in;
  wire hit_ctrl  = paddr_in == ADDR_CONTROL;
  wire hit_stat  = paddr_in == ADDR_STATUS;
  wire hit_prl   = paddr_in == ADDR_PERIOD_LOW;
  wire hit_prh   = paddr_in == ADDR_PERIOD_HIGH;
  wire hit_pru   = paddr_in == ADDR_PERIOD_UPPER;
  wire hit_cnt   = paddr_in == ADDR_COUNT;
  wire hit_res   = paddr_in == ADDR_RESULT;
  wire mapped    = hit_ctrl | hit_stat | hit_prl | hit_prh | hit_pru
                 | hit_cnt | hit_res;
  wire wr_ctrl   = wr_en & hit_ctrl & pstrb_in[0];
  wire wr_ctrl_hi = wr_en & hit_ctrl & pstrb_in[1];
  wire wr_stat   = wr_en & hit_stat & pstrb_in[0];

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire is_counter_mode = (mode == MODE_COUNTER) |
                         (mode == MODE_GATED_CNT) |
                         (mode == MODE_WIN_CNT);
  wire is_sync_mode    = ~mode[3];
  wire is_reserved     = ~is_counter_mode & ~is_sync_mode;

  // counter modes count signal edges without the timer clock
  logic tick;
  logic gate;
  logic acq_done;
  always_comb
  begin
    tick     = 1'b0;
    gate     = 1'b0;
    acq_done = 1'b0;
    case (mode)
      MODE_TIMER:
      begin
        tick = cond.clk_tick;
        gate = 1'b1;
      end
      MODE_GATED_TIMER:
      begin
        tick = cond.clk_tick;
        gate = cond.sig_level;
      end
      MODE_PERIOD_DUTY, MODE_HIGH_LOW, MODE_FLIGHT:
      begin
        tick     = cond.clk_tick;
        gate     = armed;
        acq_done = cond.sig_rise & armed;
      end
      MODE_WINDOWED, MODE_GATED_WIN:
      begin
        tick     = cond.clk_tick;
        gate     = (mode == MODE_WINDOWED) | cond.sig_level;
        acq_done = cond.win_rise & armed;
      end
      MODE_CAPTURE:
      begin
        tick     = cond.clk_tick;
        gate     = 1'b1;
        acq_done = cond.win_rise;
      end
      MODE_COUNTER:
      begin
        tick = cond.sig_rise;
        gate = 1'b1;
      end
      MODE_GATED_CNT:
      begin
        tick = cond.sig_rise;
        gate = cond.win_level;
      end
      MODE_WIN_CNT:
      begin
        tick     = cond.sig_rise;
        gate     = cond.win_level;
        acq_done = cond.win_fall;
      end
      default:
      begin
        tick = 1'b0;
        gate = 1'b0;
      end
    endcase
  end

  wire counting  = run_request_bit & gate & tick & ~is_reserved;
  wire at_period = count_value == period_value;
  wire match_evt = counting & at_period;
  wire acq_evt   = run_request_bit & acq_done & ~is_reserved;
  wire stop_now  = acq_evt & ~repeat_acq;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      mode            <= MODE_RESET;
      run_request_bit <= 1'b0;
      repeat_acq      <= 1'b0;
      window_polarity_select            <= 1'b0;
      signal_polarity_select            <= 1'b0;
      clock_polarity_select            <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        mode       <= pwdata_in[CTRL_MODE_LSB +: 4];
        repeat_acq <= pwdata_in[CTRL_REPEAT_BIT];
        window_polarity_select       <= pwdata_in[CTRL_WINDOW_POLARITY_SELECT_BIT];
        signal_polarity_select       <= pwdata_in[CTRL_SIGNAL_POLARITY_SELECT_BIT];
      end
      if (wr_ctrl_hi)
        clock_polarity_select <= pwdata_in[CTRL_CLOCK_POLARITY_SELECT_BIT];
      // hardware stop wins over a same-cycle software set
      if (stop_now)
        run_request_bit <= 1'b0;
      else if (wr_ctrl)
        run_request_bit <= pwdata_in[CTRL_RUN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // period register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      period_value <= PERIOD_RESET;
    else
    begin
      if (wr_en & hit_prl & pstrb_in[0])
        period_value[7:0] <= pwdata_in[7:0];
      if (wr_en & hit_prh & pstrb_in[0])
        period_value[15:8] <= pwdata_in[7:0];
      if (wr_en & hit_pru & pstrb_in[0])
        period_value[23:16] <= pwdata_in[7:0];
    end
  end

  // ----------------------------------------------------------------
  // counter, acquisition and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      count_value <= 24'h000000;
      result      <= 24'h000000;
      armed       <= 1'b0;
      match_flag  <= 1'b0;
      acq_flag    <= 1'b0;
      match_out   <= 1'b0;
    end
    else
    begin
      if (match_evt)
        count_value <= 24'h000000;
      else if (acq_evt & repeat_acq)
        count_value <= 24'h000000;
      else if (counting)
        count_value <= count_value + 24'h000001;
      if (acq_evt)
        result <= count_value;
      if (~run_request_bit)
        armed <= 1'b0;
      else if (cond.sig_rise | cond.win_rise)
        armed <= 1'b1;
      // set wins over a software clear in the same cycle
      if (match_evt)
        match_flag <= 1'b1;
      else if (wr_stat & pwdata_in[STAT_MATCH_BIT])
        match_flag <= 1'b0;
      if (acq_evt)
        acq_flag <= 1'b1;
      else if (wr_stat & pwdata_in[STAT_ACQ_BIT])
        acq_flag <= 1'b0;
      match_out <= match_evt;
    end
  end

  // ----------------------------------------------------------------
  // run status: synchronous modes see the request late, like their
  // inputs, so the flag is delayed to match
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      run_lag         <= 1'b0;
      run_status_flag <= 1'b0;
      run_status_out  <= 1'b0;
    end
    else
    begin
      run_lag <= run_request_bit & ~is_reserved;
      if (is_counter_mode)
        run_status_flag <= run_request_bit;
      else
        run_status_flag <= run_lag;
      run_status_out <= run_status_flag;
    end
  end

  // ----------------------------------------------------------------
  // read path; one wait-free access phase
  // ----------------------------------------------------------------
  // narrow registers sit in the low byte, upper bits read as zero
  function automatic logic [31:0] byte_lane(input logic [7:0] b);
    return {24'h000000, b};
  endfunction : byte_lane

  wire [31:0] ctrl_word = {23'h000000, clock_polarity_select, signal_polarity_select, window_polarity_select, repeat_acq,
                           run_request_bit, mode};
  wire [31:0] stat_word = {29'h00000000, acq_flag, match_flag,
                           run_status_flag};
  wire [31:0] rd_word   =
      hit_ctrl ? ctrl_word :
      hit_stat ? stat_word :
      hit_prl  ? byte_lane(period_value[7:0]) :
      hit_prh  ? byte_lane(period_value[15:8]) :
      hit_pru  ? byte_lane(period_value[23:16]) :
      hit_cnt  ? {8'h00, count_value} :
      hit_res  ? {8'h00, result} : 32'h00000000;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      prdata_out  <= 32'h00000000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~mapped;
      if (psel_in & ~penable_in & ~pwrite_in)
        prdata_out <= rd_word;
      else if (rd_en & pready_out)
        prdata_out <= 32'h00000000;
    end
  end
endmodule : smt_core
`default_nettype wire

// ---- test/smt_core_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module smt_core_monitor
  import smt_pkg::*;
(
  input wire logic        clk_in,         // system clock
  input wire logic        reset_in,       // synchronous reset
  input wire logic        psel_in,        // apb select
  input wire logic        penable_in,     // apb enable
  input wire logic        pwrite_in,      // apb direction
  input wire logic [7:0]  paddr_in,       // apb address
  input wire logic [31:0] pwdata_in,      // apb write data
  input wire logic [3:0]  pstrb_in,       // apb strobes
  input wire logic        pready_out,     // apb ready
  input wire logic        pslverr_out,    // apb error
  input wire logic        run_status_out, // run status flag
  input wire logic        match_out       // period match pulse
);
  logic       wr_ctrl;
  logic       unmapped;
  logic [3:0] mode_q;
  assign wr_ctrl = psel_in && penable_in && pready_out && pwrite_in
                   && paddr_in == ADDR_CONTROL;
  assign unmapped = !(paddr_in inside {ADDR_CONTROL, ADDR_STATUS,
    ADDR_PERIOD_LOW, ADDR_PERIOD_HIGH, ADDR_PERIOD_UPPER, ADDR_COUNT,
    ADDR_RESULT});
  // shadow of the mode field, needed to judge reserved codes
  always_ff @(posedge clk_in)
    if (reset_in)
      mode_q <= MODE_RESET;
    else if (wr_ctrl && pstrb_in[0])
      mode_q <= pwdata_in[3:0];
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  // ----
  // checks
  // ----
  ready_timing_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("ready missing in first access cycle");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  err_decode_a: assert property (pready_out |-> pslverr_out == unmapped)
    else $error("error flag does not match address decode");
  match_pulse_a: assert property (match_out |=> !match_out)
    else $error("match pulse longer than one cycle");
  reserved_idle_a: assert property (mode_q > 4'hA
    && $past(mode_q, 3) > 4'hA |-> !run_status_out && !match_out)
    else $error("activity in reserved mode");
  run_start_a: assert property (wr_ctrl
    && pwdata_in[4] && pwdata_in[3:0] == 4'h0 |-> ##[1:4] run_status_out)
    else $error("run status did not follow start");
  run_stop_a: assert property (wr_ctrl
    && !pwdata_in[4] |-> ##[1:4] !run_status_out)
    else $error("run status did not follow stop");
  reset_quiet_a: assert property ($fell(reset_in)
    |-> !run_status_out && !match_out && !pready_out)
    else $error("outputs active after reset");
  cover property (wr_ctrl && pwdata_in[4]);
  cover property (match_out);
  cover property (pready_out && pslverr_out);
endmodule : smt_core_monitor
bind smt_core smt_core_monitor smt_core_monitor_i (.clk_in, .reset_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in,
  .pready_out, .pslverr_out, .run_status_out, .match_out);
`default_nettype wire

// ---- test/smt_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module smt_far_model
(
  input  wire logic       clk_in,   // system clock
  input  wire logic [3:0] half_in,  // timer clock half period, 0 stops
  output logic            tclk_out, // timer clock source
  output logic            sig_out,  // measured signal
  output logic            win_out   // window, half the signal rate
);
  logic [3:0] cnt = 4'h0;
  logic [2:0] div = 3'h0;
  initial tclk_out = 1'b0;
  // a stopped source holds its level, as a real oscillator gate would
  always @(posedge clk_in)
    if (half_in == 4'h0)
      cnt <= 4'h0;
    else if (cnt >= half_in - 4'h1)
    begin
      cnt      <= 4'h0;
      tclk_out <= ~tclk_out;
      div      <= div + 3'h1;
    end
    else
      cnt <= cnt + 4'h1;
  assign sig_out = div[1];
  assign win_out = div[2];
endmodule : smt_far_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb
  import smt_pkg::*;
;
  logic        clk_in, reset_in, psel_in, penable_in, pwrite_in, err;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd, c0;
  logic [3:0]  pstrb_in, half;
  logic        pready_out, pslverr_out, signal_in, window_in, tclk_in;
  logic        run_status_out, match_out;
  int          failures, n_tests, k;
  smt_core smt_core_i (.clk_in, .reset_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
    .pready_out, .pslverr_out, .signal_in, .window_in, .tclk_in,
    .run_status_out, .match_out);
  smt_far_model smt_far_model_i (.clk_in, .half_in(half),
    .tclk_out(tclk_in), .sig_out(signal_in), .win_out(window_in));
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // ----
  // tasks
  // ----
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic give_up(input int n, input int lim);
    if (n >= lim)
    begin
      failures++;
      close_out();
    end
  endtask : give_up
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    int n;
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 16);
    rd  = prdata_out;
    err = pslverr_out;
    give_up(pready_out === 1'b1 ? 0 : n, 16);
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask : xfer
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    check(nm, e, rd);
  endtask : rchk
  function automatic logic [31:0] ctl(input logic [3:0] m,
                                      input logic run, rep, cp);
    return {23'h0, cp, 2'b00, rep, run, m};
  endfunction : ctl
  initial
  begin
    failures = 0;
    n_tests = 0;
    reset_in = 1'b1;
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    pstrb_in = 4'hF;
    half = 4'h2;
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    rchk("prd_low", ADDR_PERIOD_LOW, 32'hFF);
    rchk("prd_high", ADDR_PERIOD_HIGH, 32'hFF);
    rchk("prd_upper", ADDR_PERIOD_UPPER, 32'hFF);
    xfer(ADDR_PERIOD_LOW, 1'b1, 32'hFFFF_FF5A);
    rchk("prd_low_rw", ADDR_PERIOD_LOW, 32'h5A);
    xfer(8'h1C, 1'b0, 32'h0);
    check("unmapped_err", 32'h1, {31'h0, err});
    check("unmapped_rd", 32'h0, rd);
    $display("test registers done");
    xfer(ADDR_PERIOD_HIGH, 1'b1, 32'h0);
    xfer(ADDR_PERIOD_UPPER, 1'b1, 32'h0);
    xfer(ADDR_PERIOD_LOW, 1'b1, 32'h5);
    xfer(ADDR_CONTROL, 1'b1, ctl(MODE_TIMER, 1'b1, 1'b1, 1'b0));
    k = 0;
    while (match_out !== 1'b1 && k < 400)
    begin
      @(posedge clk_in);
      k++;
    end
    give_up(k, 400);
    xfer(ADDR_COUNT, 1'b0, 32'h0);
    check("count_bound", 32'h1, 32'(rd <= 32'h5));
    rchk("run_kept", ADDR_CONTROL, ctl(4'h0, 1'b1, 1'b1, 1'b0));
    xfer(ADDR_CONTROL, 1'b1, 32'h0);
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    check("match_flag", 32'h1, {31'h0, rd[STAT_MATCH_BIT]});
    xfer(ADDR_STATUS, 1'b1, 32'h2);
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    check("match_clear", 32'h0, {31'h0, rd[STAT_MATCH_BIT]});
    $display("test timer done");
    for (int m = 0; m < 16; m++)
    begin
      xfer(ADDR_CONTROL, 1'b1, ctl(4'(m), 1'b1, 1'b1, 1'b0));
      repeat (12) @(posedge clk_in);
      check("mode_run", 32'(m < 11), {31'h0, run_status_out});
      xfer(ADDR_CONTROL, 1'b1, 32'h0);
    end
    $display("test modes done");
    xfer(ADDR_CONTROL, 1'b1, ctl(MODE_PERIOD_DUTY, 1'b1, 1'b0, 1'b0));
    k = 0;
    do
    begin
      xfer(ADDR_CONTROL, 1'b0, 32'h0);
      k++;
    end
    while (rd[CTRL_RUN_BIT] !== 1'b0 && k < 100);
    give_up(k, 100);
    xfer(ADDR_COUNT, 1'b0, 32'h0);
    c0 = rd;
    repeat (40) @(posedge clk_in);
    rchk("count_held", ADDR_COUNT, c0);
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    check("single_acq", 32'h1, {31'h0, rd[STAT_ACQ_BIT]});
    xfer(ADDR_STATUS, 1'b1, 32'h1 << STAT_ACQ_BIT);
    $display("test single done");
    half <= 4'h4;
    xfer(ADDR_CONTROL, 1'b1, ctl(MODE_PERIOD_DUTY, 1'b1, 1'b1, 1'b1));
    repeat (200) @(posedge clk_in);
    rchk("repeat_run", ADDR_CONTROL, ctl(4'h2, 1'b1, 1'b1, 1'b1));
    check("repeat_flag", 32'h1, {31'h0, run_status_out});
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    check("repeat_stat_run", 32'h1, {31'h0, rd[STAT_RUN_BIT]});
    check("repeat_acq", 32'h1, {31'h0, rd[STAT_ACQ_BIT]});
    xfer(ADDR_PERIOD_UPPER, 1'b1, 32'h12);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    rchk("prd_rerst", ADDR_PERIOD_UPPER, 32'hFF);
    rchk("ctl_rerst", ADDR_CONTROL, 32'h0);
    $display("test repeat and reset done");
    // a held signal only moves when its polarity select flips
    half <= 4'h0;
    xfer(ADDR_CONTROL, 1'b1, ctl(MODE_COUNTER, 1'b1, 1'b1, 1'b0));
    repeat (8) @(posedge clk_in);
    xfer(ADDR_COUNT, 1'b0, 32'h0);
    c0 = rd;
    xfer(ADDR_CONTROL, 1'b1, ctl(MODE_COUNTER, 1'b1, 1'b1, 1'b0)
         | (32'h1 << CTRL_SIGNAL_POLARITY_SELECT_BIT));
    xfer(ADDR_CONTROL, 1'b1, ctl(MODE_COUNTER, 1'b1, 1'b1, 1'b0));
    rchk("signal_polarity_select_edge", ADDR_COUNT, c0 + 32'h1);
    $display("test polarity done");
    close_out();
  end
endmodule : tb
`default_nettype wire
